// ===== rtl/pbm_basic_mode_control.sv
// Purpose: Management register bank with the basic mode control register
// Assumes: One write or read strobe per cycle, read data in the next cycle
// Notes:   Straps load one cycle after reset release and after soft reset
//
// Our own choice: the strobed register port.
module pbm_basic_mode_control (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        strap_speed_pin,
  input  wire logic        strap_autoneg_pin,
  input  wire logic        strap_duplex_pin,
  input  wire logic        power_down_interrupt_pin_n,
  input  wire logic        an_started,
  input  wire logic        ev_cor_in,
  input  wire logic        ev_lh_in,
  input  wire logic        ev_ll_in,
  input  wire logic        ev_sc_in,
  input  wire logic [3:0]  mii_txd,
  input  wire logic        mii_tx_en,
  input  wire logic [3:0]  line_rxd,
  input  wire logic        line_rx_dv,
  output logic      [3:0]  mii_rxd,
  output logic             mii_rx_dv,
  output logic             mii_rx_oe,
  output logic      [3:0]  line_txd,
  output logic             line_tx_en,
  output logic             phy_soft_reset,
  output logic             power_down,
  output logic             autoneg_en,
  output logic             force_speed_100,
  output logic             force_full_duplex,
  output logic             an_restart,
  output logic             collision_test,
  output logic             soft_option
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [15:0]                        bmc;
    logic [pbm_pkg::RST_CNT_W-1:0]      rst_cnt;
    logic                               strap_due;
    logic                               strap_mode;
    logic [2:0]                         cfg;
    logic                               cfg_set;
    logic                               opt_pend;
    logic                               opt_val;
    logic                               opt_dflt;
    logic [15:0]                        rdata;
    logic                               o_reset;
    logic                               o_pdown;
    logic                               o_an;
    logic                               o_speed;
    logic                               o_duplex;
    logic                               o_restart;
    logic                               o_coll;
  } pbm_bmc_s;

  pbm_bmc_s s_q;
  pbm_bmc_s s_d;

  logic [pbm_pkg::NUM_FLAGS-1:0] flags;
  logic [pbm_pkg::NUM_FLAGS-1:0] flag_events;
  logic                          evt_rd;

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic pbm_pkg::pbm_flag_e kind_of(input int idx);
    case (idx)
      0:       kind_of = pbm_pkg::PBM_FLAG_COR;
      1:       kind_of = pbm_pkg::PBM_FLAG_LH;
      2:       kind_of = pbm_pkg::PBM_FLAG_LL;
      default: kind_of = pbm_pkg::PBM_FLAG_SC;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Status flags
  assign flag_events = {ev_sc_in, ev_ll_in, ev_lh_in, ev_cor_in};
  assign evt_rd      = reg_rd & hit(reg_addr, pbm_pkg::EVENT_STAT_OFS) & ~s_q.o_pdown;

  for (genvar i = 0; i < pbm_pkg::NUM_FLAGS; i++) begin : g_flag
    pbm_event_flag #(
      .KIND (kind_of(i))
    ) u_flag (
      .mclk     (mclk),
      .rst      (rst),
      .event_in (flag_events[i]),
      .rd_clr   (evt_rd),
      .flag     (flags[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic        busy;
  logic        bmc_wr;
  logic        ctrl_wr;
  logic        cfg_wr;
  logic        commit;
  logic [2:0]  strap_val;
  logic [15:0] bmc_rd;

  always_comb begin
    s_d       = s_q;
    busy      = s_q.bmc[pbm_pkg::BMC_SOFT_RESET] | s_q.strap_due;
    bmc_wr    = reg_wr & hit(reg_addr, pbm_pkg::BMC_OFS) & ~busy;
    // Power down keeps only the control register reachable
    ctrl_wr   = reg_wr & hit(reg_addr, pbm_pkg::STRAP_CTRL_OFS) & ~s_q.o_pdown;
    cfg_wr    = reg_wr & hit(reg_addr, pbm_pkg::SOFT_CFG_OFS) & s_q.strap_mode & ~s_q.o_pdown;
    commit    = ctrl_wr & s_q.strap_mode & reg_wdata[pbm_pkg::STRAP_COMMIT];
    strap_val = s_q.cfg_set ? s_q.cfg
                            : {strap_duplex_pin, strap_autoneg_pin, strap_speed_pin};
    bmc_rd    = {s_q.bmc[15:8], s_q.bmc[pbm_pkg::BMC_COLL_TEST], 7'h00};
    bmc_rd[pbm_pkg::BMC_SOFT_RESET] = busy;

    // Plain write of the control register, only the bits in BMC_RW_MASK plus bit 15
    if (bmc_wr) begin
      s_d.bmc = (reg_wdata & pbm_pkg::BMC_RW_MASK) | (s_q.bmc & ~pbm_pkg::BMC_RW_MASK);
      s_d.bmc[pbm_pkg::BMC_SOFT_RESET] = reg_wdata[pbm_pkg::BMC_SOFT_RESET];
      s_d.rst_cnt = '0;
    end

    // Restart request: written one sets while autoneg is enabled, start clears, written zero ignored
    s_d.bmc[pbm_pkg::BMC_AN_RESTART] = (s_q.bmc[pbm_pkg::BMC_AN_RESTART] & ~an_started)
      | (bmc_wr & reg_wdata[pbm_pkg::BMC_AN_RESTART]);
    if (!s_d.bmc[pbm_pkg::BMC_AUTONEG]) begin
      s_d.bmc[pbm_pkg::BMC_AN_RESTART] = 1'b0;
    end

    // Soft reset sequence
    if (s_q.bmc[pbm_pkg::BMC_SOFT_RESET]) begin
      if (s_q.rst_cnt == pbm_pkg::RST_CNT_W'(pbm_pkg::SOFT_RESET_CYCLES - 1)) begin
        s_d.bmc       = pbm_pkg::BMC_RESET;
        s_d.strap_due = 1'b1;
        s_d.opt_val   = s_q.opt_dflt;
        s_d.rst_cnt   = '0;
      end else begin
        s_d.rst_cnt = s_q.rst_cnt + 1'b1;
      end
    end

    // Strap relatch after hardware or soft reset
    if (s_q.strap_due) begin
      s_d.strap_due = 1'b0;
      s_d.bmc[pbm_pkg::BMC_SPEED]   = strap_val[pbm_pkg::CFG_SPEED];
      s_d.bmc[pbm_pkg::BMC_AUTONEG] = strap_val[pbm_pkg::CFG_AUTONEG];
      s_d.bmc[pbm_pkg::BMC_DUPLEX]  = strap_val[pbm_pkg::CFG_DUPLEX];
      s_d.cfg = strap_val;
    end

    // Soft strap mode, config bits and commit
    if (ctrl_wr) begin
      s_d.strap_mode = reg_wdata[pbm_pkg::STRAP_MODE];
      if (s_q.strap_mode) begin
        s_d.opt_pend = reg_wdata[pbm_pkg::STRAP_OPTION];
      end else begin
        s_d.opt_val  = reg_wdata[pbm_pkg::STRAP_OPTION];
      end
    end
    if (cfg_wr) begin
      s_d.cfg = reg_wdata[2:0];
    end
    if (commit) begin
      s_d.strap_mode = 1'b0;
      s_d.cfg_set    = 1'b1;
      s_d.opt_val    = s_q.opt_pend;
      s_d.opt_dflt   = s_q.opt_pend;
      s_d.bmc[pbm_pkg::BMC_SPEED]   = s_q.cfg[pbm_pkg::CFG_SPEED];
      s_d.bmc[pbm_pkg::BMC_AUTONEG] = s_q.cfg[pbm_pkg::CFG_AUTONEG];
      s_d.bmc[pbm_pkg::BMC_DUPLEX]  = s_q.cfg[pbm_pkg::CFG_DUPLEX];
    end

    // Pin low sets the power down bit and wins over a written zero
    if (!power_down_interrupt_pin_n) begin
      s_d.bmc[pbm_pkg::BMC_PDOWN] = 1'b1;
    end

    // Read data, valid only in the cycle after the strobe
    s_d.rdata = 16'h0000;
    if (reg_rd) begin
      if (hit(reg_addr, pbm_pkg::BMC_OFS)) begin
        s_d.rdata = bmc_rd;
      end else if (!s_q.o_pdown) begin
        if (hit(reg_addr, pbm_pkg::STRAP_CTRL_OFS)) begin
          s_d.rdata[pbm_pkg::STRAP_MODE]   = s_q.strap_mode;
          s_d.rdata[pbm_pkg::STRAP_OPTION] = s_q.opt_val;
        end else if (hit(reg_addr, pbm_pkg::SOFT_CFG_OFS) && s_q.strap_mode) begin
          s_d.rdata[2:0] = s_q.cfg;
        end else if (hit(reg_addr, pbm_pkg::EVENT_STAT_OFS)) begin
          s_d.rdata[pbm_pkg::NUM_FLAGS-1:0] = flags;
          s_d.rdata[15:pbm_pkg::EVT_FIXED_LSB] = pbm_pkg::EVT_FIXED_VAL;
        end
      end
    end

    // Registered control outputs
    s_d.o_reset   = s_d.bmc[pbm_pkg::BMC_SOFT_RESET] | s_d.strap_due;
    s_d.o_pdown   = s_d.bmc[pbm_pkg::BMC_PDOWN] | ~power_down_interrupt_pin_n;
    s_d.o_an      = s_d.bmc[pbm_pkg::BMC_AUTONEG];
    s_d.o_speed   = s_d.bmc[pbm_pkg::BMC_SPEED] & ~s_d.bmc[pbm_pkg::BMC_AUTONEG];
    s_d.o_duplex  = s_d.bmc[pbm_pkg::BMC_DUPLEX] & ~s_d.bmc[pbm_pkg::BMC_AUTONEG];
    s_d.o_restart = s_d.bmc[pbm_pkg::BMC_AN_RESTART];
    s_d.o_coll    = s_d.bmc[pbm_pkg::BMC_COLL_TEST];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q           <= '0;
      s_q.bmc       <= pbm_pkg::BMC_RESET;
      s_q.strap_due <= 1'b1;
      s_q.o_reset   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // MII steering
  pbm_mii_path u_mii (
    .mclk       (mclk),
    .rst        (rst),
    .loopback   (s_q.bmc[pbm_pkg::BMC_LOOPBACK]),
    .isolate    (s_q.bmc[pbm_pkg::BMC_ISOLATE]),
    .mii_txd    (mii_txd),
    .mii_tx_en  (mii_tx_en),
    .line_rxd   (line_rxd),
    .line_rx_dv (line_rx_dv),
    .mii_rxd    (mii_rxd),
    .mii_rx_dv  (mii_rx_dv),
    .mii_rx_oe  (mii_rx_oe),
    .line_txd   (line_txd),
    .line_tx_en (line_tx_en)
  );

  assign reg_rdata         = s_q.rdata;
  assign phy_soft_reset    = s_q.o_reset;
  assign power_down        = s_q.o_pdown;
  assign autoneg_en        = s_q.o_an;
  assign force_speed_100   = s_q.o_speed;
  assign force_full_duplex = s_q.o_duplex;
  assign an_restart        = s_q.o_restart;
  assign collision_test    = s_q.o_coll;
  assign soft_option       = s_q.opt_val;

endmodule

// ===== rtl/pbm_pkg.sv
// Purpose: Shared constants and types of the basic mode control register bank
// Assumes: One 25 MHz clock, registers reached over a plain strobe port
// Notes:   Offsets and field positions below are used by the register bank design file; the event flag file uses only the flag kinds
//
// Behaviour
// - Clear-on-read bit returns value, then clears
// - Latched-high flag holds one until read
// - Latched-low flag holds zero until read
// - Fixed read-only bits ignore writes, read constant
// - Event-tracking flag follows event, clears itself
// - Strap bits load pin level after reset
// - Soft strap bit commits on config done
// - Soft config bits reachable only in strap mode
// - Soft config overrides pin, defaults from pin
// - Bit 15 soft reset, self-clears, relatches straps
// - Bit 14 loops transmit data to receive
// - Bit 13 forces speed, one is 100
// - Bit 12 autoneg enable, masks speed and duplex
// - Bit 11 powers down, minimal register access
// - Power down is bit 11 or pin
// - Bit 10 isolates MII, management stays alive
// - Plain read-write bits store written value
// - Bit 9 restarts autoneg, clears when started
// - Bit 8 forces duplex, one is full
// - Bits 6 to 0 read zero
package pbm_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [4:0] BMC_OFS        = 5'h00;
  localparam logic [4:0] STRAP_CTRL_OFS = 5'h10;
  localparam logic [4:0] SOFT_CFG_OFS   = 5'h11;
  localparam logic [4:0] EVENT_STAT_OFS = 5'h12;

  ////////////////////////////////////////////////////////////////////////////
  // Basic mode control fields
  localparam int unsigned BMC_SOFT_RESET = 15;
  localparam int unsigned BMC_LOOPBACK   = 14;
  localparam int unsigned BMC_SPEED      = 13;
  localparam int unsigned BMC_AUTONEG    = 12;
  localparam int unsigned BMC_PDOWN      = 11;
  localparam int unsigned BMC_ISOLATE    = 10;
  localparam int unsigned BMC_AN_RESTART = 9;
  localparam int unsigned BMC_DUPLEX     = 8;
  localparam int unsigned BMC_COLL_TEST  = 7;
  localparam logic [15:0] BMC_RESET      = 16'h3100;
  localparam logic [15:0] BMC_RW_MASK    = 16'h7d80;

  // Strap control fields
  localparam int unsigned STRAP_MODE   = 0;
  localparam int unsigned STRAP_COMMIT = 1;
  localparam int unsigned STRAP_OPTION = 2;
  // Soft config fields
  localparam int unsigned CFG_SPEED   = 0;
  localparam int unsigned CFG_AUTONEG = 1;
  localparam int unsigned CFG_DUPLEX  = 2;
  // Event status: flags in low bits, fixed value on top
  localparam int unsigned EVT_FIXED_LSB = 12;
  localparam logic [3:0]  EVT_FIXED_VAL = 4'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_MHZ           = 25;
  localparam int unsigned SOFT_RESET_NS     = 1000;
  localparam int unsigned SOFT_RESET_CYCLES = (SOFT_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RST_CNT_W         = 8;

  typedef enum logic [1:0] {
    PBM_FLAG_COR,
    PBM_FLAG_LH,
    PBM_FLAG_LL,
    PBM_FLAG_SC
  } pbm_flag_e;

  localparam int unsigned NUM_FLAGS = 4;

endpackage

// ===== rtl/pbm_event_flag.sv
// Purpose: One status flag of a selectable access kind
// Assumes: rd_clr is a one-cycle pulse on a read of the holding register
// Notes:   An event in the read cycle wins over the clear
module pbm_event_flag #(
  parameter pbm_pkg::pbm_flag_e KIND = pbm_pkg::PBM_FLAG_COR
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic event_in,
  input  wire logic rd_clr,
  output logic      flag
);

  typedef struct packed {
    logic flag;
  } pbm_flag_s;

  pbm_flag_s s_q;
  pbm_flag_s s_d;

  always_comb begin
    s_d = s_q;
    case (KIND)
      pbm_pkg::PBM_FLAG_COR: s_d.flag = event_in | (s_q.flag & ~rd_clr);
      pbm_pkg::PBM_FLAG_LH:  s_d.flag = event_in | (s_q.flag & ~rd_clr);
      pbm_pkg::PBM_FLAG_LL:  s_d.flag = rd_clr ? event_in : (s_q.flag & event_in);
      pbm_pkg::PBM_FLAG_SC:  s_d.flag = event_in;
      default:               s_d.flag = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '{flag: (KIND == pbm_pkg::PBM_FLAG_LL)};
    end else begin
      s_q <= s_d;
    end
  end

  assign flag = s_q.flag;

endmodule

// ===== rtl/pbm_mii_path.sv
// Purpose: MII receive and transmit side steering for loopback and isolate
// Assumes: MII nibbles are synchronous to mclk
// Notes:   Isolate wins over loopback; all outputs registered
module pbm_mii_path (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       loopback,
  input  wire logic       isolate,
  input  wire logic [3:0] mii_txd,
  input  wire logic       mii_tx_en,
  input  wire logic [3:0] line_rxd,
  input  wire logic       line_rx_dv,
  output logic      [3:0] mii_rxd,
  output logic            mii_rx_dv,
  output logic            mii_rx_oe,
  output logic      [3:0] line_txd,
  output logic            line_tx_en
);

  typedef struct packed {
    logic [3:0] rxd;
    logic       rx_dv;
    logic       rx_oe;
    logic [3:0] txd;
    logic       tx_en;
  } pbm_mii_s;

  pbm_mii_s s_q;
  pbm_mii_s s_d;

  always_comb begin
    s_d       = s_q;
    s_d.rx_oe = ~isolate;
    if (isolate) begin
      s_d.rxd   = 4'h0;
      s_d.rx_dv = 1'b0;
      s_d.txd   = 4'h0;
      s_d.tx_en = 1'b0;
    end else if (loopback) begin
      s_d.rxd   = mii_txd;
      s_d.rx_dv = mii_tx_en;
      s_d.txd   = 4'h0;
      s_d.tx_en = 1'b0;
    end else begin
      s_d.rxd   = line_rxd;
      s_d.rx_dv = line_rx_dv;
      s_d.txd   = mii_txd;
      s_d.tx_en = mii_tx_en;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mii_rxd    = s_q.rxd;
  assign mii_rx_dv  = s_q.rx_dv;
  assign mii_rx_oe  = s_q.rx_oe;
  assign line_txd   = s_q.txd;
  assign line_tx_en = s_q.tx_en;

endmodule

// ===== testbench/pbm_bmc_monitor.sv
// Purpose: Port assertions for the basic mode control register bank
// Assumes: One clock domain, asynchronous active high reset
// Notes:   Bound to the top design module below
module pbm_bmc_monitor (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        power_down_interrupt_pin_n,
  input wire logic [3:0]  mii_rxd,
  input wire logic        mii_rx_dv,
  input wire logic        mii_rx_oe,
  input wire logic [3:0]  line_txd,
  input wire logic        phy_soft_reset,
  input wire logic        power_down,
  input wire logic        autoneg_en,
  input wire logic        force_speed_100,
  input wire logic        force_full_duplex,
  input wire logic        an_restart
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic [7:0] busy_cnt_q;

  // Length of the current busy stretch
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) busy_cnt_q <= 8'h00;
    else if (phy_soft_reset) busy_cnt_q <= busy_cnt_q + 8'h01;
    else busy_cnt_q <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence soft_rst_req;
    reg_wr && reg_addr == 5'h00 && reg_wdata[15] && !phy_soft_reset;
  endsequence
  sequence busy_run;
    phy_soft_reset [*8];
  endsequence
  sequence ctrl_read;
    reg_rd && reg_addr == 5'h00 && !phy_soft_reset;
  endsequence

  soft_busy_a: assert property (soft_rst_req |=> busy_run)
    else $error("soft reset not busy after request");
  busy_len_a: assert property (busy_cnt_q <= 8'd27)
    else $error("soft reset busy too long");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  read_ctrl_a: assert property (ctrl_read |=> reg_rdata[6:0] == 7'h00 &&
    reg_rdata[12] == $past(autoneg_en) && reg_rdata[11] == $past(power_down))
    else $error("control read mismatch");
  an_mask_a: assert property (autoneg_en |-> !force_speed_100 && !force_full_duplex)
    else $error("forced mode while negotiating");
  pin_pdown_a: assert property (!power_down_interrupt_pin_n |=> power_down)
    else $error("pin low without power down");
  iso_quiet_a: assert property (!mii_rx_oe |-> mii_rxd == 4'h0 && !mii_rx_dv && line_txd == 4'h0)
    else $error("isolated port not quiet");
  restart_off_a: assert property (!autoneg_en |-> !an_restart)
    else $error("restart while negotiation off");
endmodule

bind pbm_basic_mode_control pbm_bmc_monitor u_mon (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .power_down_interrupt_pin_n, .mii_rxd, .mii_rx_dv, .mii_rx_oe, .line_txd,
  .phy_soft_reset, .power_down, .autoneg_en, .force_speed_100, .force_full_duplex, .an_restart);

// ===== testbench/pbm_sme_model.sv
// Purpose: Station management side driving the register port
// Assumes: Strobes one cycle, read data in the cycle after the read
// Notes:   Write data is inverted once the write is over
module pbm_sme_model (
  input  wire logic        mclk,
  output logic      [4:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ===== testbench/phy_basic_mode_control_regs_tb.sv
// Purpose: Self-checking bench for the basic mode control register bank
// Assumes: 25 MHz clock, reset held for 8 cycles
// Notes:   Straps at reset: speed 0, negotiation 1, duplex 0
module phy_basic_mode_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk, rst, reg_wr, reg_rd;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic        strap_speed_pin, strap_autoneg_pin, strap_duplex_pin, power_down_interrupt_pin_n;
  logic        an_started, ev_cor_in, ev_lh_in, ev_ll_in, ev_sc_in;
  logic [3:0]  mii_txd, line_rxd, mii_rxd, line_txd;
  logic        mii_tx_en, line_rx_dv, mii_rx_dv, mii_rx_oe, line_tx_en, phy_soft_reset, power_down;
  logic        autoneg_en, force_speed_100, force_full_duplex, an_restart, collision_test, soft_option;
  int          mismatches, cmp_count;
  logic [15:0] vals [4] = '{16'h2100, 16'h0000, 16'h3100, 16'h01ff};

  pbm_basic_mode_control DUT (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .strap_speed_pin, .strap_autoneg_pin, .strap_duplex_pin, .power_down_interrupt_pin_n, .an_started,
    .ev_cor_in, .ev_lh_in, .ev_ll_in, .ev_sc_in, .mii_txd, .mii_tx_en, .line_rxd, .line_rx_dv, .mii_rxd,
    .mii_rx_dv, .mii_rx_oe, .line_txd, .line_tx_en, .phy_soft_reset, .power_down, .autoneg_en,
    .force_speed_100, .force_full_duplex, .an_restart, .collision_test, .soft_option);
  pbm_sme_model SME (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chb(input string n, input logic e, input logic s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %b seen %b", n, e, s);
    end
  endtask

  task automatic rdc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e, input string n);
    logic [15:0] d;
    SME.rd(a, d);
    chk(n, e, d & m);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_strap();
    rdc(5'h00, 16'hffff, 16'h1000, "ctrl after reset");
    SME.wr(5'h10, 16'h0001);
    rdc(5'h11, 16'hffff, 16'h0002, "soft cfg default");
    SME.wr(5'h11, 16'h0005);
    SME.wr(5'h10, 16'h0005);
    chb("option pending", 1'b0, soft_option);
    SME.wr(5'h10, 16'h0007);
    chb("option committed", 1'b1, soft_option);
    rdc(5'h00, 16'hffff, 16'h2100, "ctrl after commit");
    rdc(5'h11, 16'hffff, 16'h0000, "soft cfg hidden");
  endtask

  task automatic t_soft();
    int i;
    SME.wr(5'h00, 16'h8000);
    rdc(5'h00, 16'h8000, 16'h8000, "reset busy bit");
    for (i = 0; i < 100 && phy_soft_reset !== 1'b0; i++) @(posedge mclk);
    if (phy_soft_reset !== 1'b0) begin
      mismatches++;
      stop_test();
    end
    #1;
    rdc(5'h00, 16'hffff, 16'h2100, "ctrl relatched");
    chb("option default", 1'b1, soft_option);
    SME.wr(5'h10, 16'h0000);
    chb("option plain rw", 1'b0, soft_option);
  endtask

  task automatic t_modes();
    foreach (vals[i]) begin
      SME.wr(5'h00, vals[i]);
      chb("force speed", vals[i][13] & ~vals[i][12], force_speed_100);
      chb("force duplex", vals[i][8] & ~vals[i][12], force_full_duplex);
      chb("collision test", vals[i][7], collision_test);
      rdc(5'h00, 16'hffff, vals[i] & 16'h7d80, "ctrl readback");
    end
    SME.wr(5'h00, 16'h1200);
    chb("restart set", 1'b1, an_restart);
    SME.wr(5'h00, 16'h1000);
    chb("restart kept", 1'b1, an_restart);
    @(posedge mclk) an_started <= 1'b1;
    @(posedge mclk) an_started <= 1'b0;
    #1;
    chb("restart cleared", 1'b0, an_restart);
  endtask

  task automatic t_mii();
    SME.wr(5'h00, 16'h4000);
    @(posedge mclk);
    mii_txd <= 4'ha;
    mii_tx_en <= 1'b1;
    line_rxd <= 4'h5;
    @(posedge mclk);
    #1;
    chk("loop rxd", 16'h000a, 16'(mii_rxd));
    chb("loop dv", 1'b1, mii_rx_dv);
    chb("loop tx quiet", 1'b0, line_tx_en);
    SME.wr(5'h00, 16'h0400);
    repeat (2) @(posedge mclk);
    #1;
    chb("isolate oe", 1'b0, mii_rx_oe);
    rdc(5'h00, 16'h0400, 16'h0400, "isolate mgmt");
    SME.wr(5'h00, 16'h0000);
    repeat (2) @(posedge mclk);
    #1;
    chk("pass rxd", 16'h0005, 16'(mii_rxd));
    chk("pass txd", 16'h000a, 16'(line_txd));
    chb("pass tx en", 1'b1, line_tx_en);
  endtask

  task automatic t_pdown();
    @(posedge mclk) power_down_interrupt_pin_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chb("pin power down", 1'b1, power_down);
    rdc(5'h00, 16'h0800, 16'h0800, "pin sets bit11");
    rdc(5'h12, 16'hffff, 16'h0000, "status hidden");
    @(posedge mclk) power_down_interrupt_pin_n <= 1'b1;
    SME.wr(5'h00, 16'h0000);
    chb("power up", 1'b0, power_down);
  endtask

  task automatic t_flags();
    @(posedge mclk);
    ev_cor_in <= 1'b1;
    ev_lh_in <= 1'b1;
    ev_ll_in <= 1'b0;
    @(posedge mclk);
    ev_cor_in <= 1'b0;
    ev_lh_in <= 1'b0;
    ev_ll_in <= 1'b1;
    rdc(5'h12, 16'hffff, 16'h6003, "flags latched");
    rdc(5'h12, 16'hffff, 16'h6004, "flags cleared");
    @(posedge mclk) ev_sc_in <= 1'b1;
    rdc(5'h12, 16'hffff, 16'h600c, "tracking set");
    @(posedge mclk) ev_sc_in <= 1'b0;
    repeat (2) @(posedge mclk);
    SME.wr(5'h12, 16'hffff);
    rdc(5'h12, 16'hffff, 16'h6004, "fixed field");
    SME.wr(5'h1f, 16'hffff);
    rdc(5'h1f, 16'hffff, 16'h0000, "unmapped");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {strap_speed_pin, strap_autoneg_pin, strap_duplex_pin} = 3'b010;
    power_down_interrupt_pin_n = 1'b1;
    {an_started, ev_cor_in, ev_lh_in, ev_sc_in} = 4'h0;
    ev_ll_in = 1'b1;
    {mii_txd, line_rxd, mii_tx_en, line_rx_dv} = 10'h000;
    mismatches = 0;
    cmp_count = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    t_strap();
    t_soft();
    t_modes();
    t_mii();
    t_pdown();
    t_flags();
    stop_test();
  end
endmodule
